// ---- rtl/sfr_defines.svh ----
`ifndef SFR_DEFINES_SVH
`define SFR_DEFINES_SVH
`define SFR_OP_READ 8'h03
`define SFR_OP_FAST 8'h0B
`define SFR_OP_DOUT 8'h3B
`define SFR_OP_DIO 8'hBB
`define SFR_OP_QOUT 8'h6B
`define SFR_OP_QIO 8'hEB
`define SFR_OP_CRST 8'hFF
`define SFR_ADDR_W 24
`define SFR_CONT_KEEP 2'h2
`define SFR_DUMMY_X1 8
`define SFR_DUMMY_DOUT 8
`define SFR_DUMMY_DIO 4
`define SFR_DUMMY_QOUT 8
`define SFR_DUMMY_QIO 6
`endif

// ---- rtl/sfr_pkg.sv ----
package sfr_pkg;
  typedef enum logic [2:0] {
    SFR_IDLE = 3'b000,
    SFR_CMD = 3'b001,
    SFR_ADDR = 3'b010,
    SFR_DUMMY = 3'b011,
    SFR_DATA = 3'b100,
    SFR_SKIP = 3'b101
  } sfr_state_t;
  typedef enum logic [1:0] {
    SFR_W1 = 2'b00,
    SFR_W2 = 2'b01,
    SFR_W4 = 2'b10
  } sfr_width_t;
endpackage

// ---- rtl/sfr_mem.sv ----
`timescale 1ns/1ps
// Flash array model; read data comes out of a register one cycle after the address.
module sfr_mem #(
  parameter int AW = 24,
  parameter int DEPTH_W = 12
) (
  input wire logic clk,
  input wire logic [AW-1:0] addr,
  output logic [7:0] rdata
);
  logic [7:0] mem_q [0:(1<<DEPTH_W)-1];
  initial begin
    for (int i = 0; i < (1 << DEPTH_W); i++) begin
      mem_q[i] = 8'hFF;
    end
  end
  always_ff @(posedge clk) begin
    rdata <= mem_q[addr[DEPTH_W-1:0]];
  end
endmodule

// ---- rtl/sfr_read_front.sv ----
`timescale 1ns/1ps
// Function
// - Plain read: opcode, address, data immediately.
// - Sample on rising, drive on falling clock.
// - Address increments per byte, wraps to zero.
// - Chip select high stops output anytime.
// - Fast read adds one dummy byte.
// - Busy device ignores fast, dual, quad opcodes; continuation frames still read.
// - Dual output: x1 address, 8 dummies, x2 data.
// - Dual I/O: x2 address, dummies and data.
// - Dual I/O continuation bits 10 skip opcode.
// - Other bits need opcode; continuation frames never decode reset.
// - Quad output: x1 address, 8 dummies, x4 data.
// - Quad I/O: x4 address, mode byte, dummies.
// - Quad I/O continuation bits 10 skip opcode.
// - Busy flag gates read command rejection.
`include "sfr_defines.svh"
module sfr_read_front #(
  parameter int MEM_DEPTH_W = 12
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic CS_N,
  input wire logic SCLK,
  input wire logic [3:0] IO_IN,
  output logic [3:0] IO_OUT,
  output logic [3:0] IO_OE,
  input wire logic BUSY_FLAG,
  input wire logic QUAD_LINES_ENABLE,
  output logic CONT_MODE
);
  import sfr_pkg::*;

  typedef struct packed {
    logic [1:0] cs_s;
    logic [1:0] ck_s;
    logic [7:0] io0_s;
    logic ck_d;
    sfr_pkg::sfr_state_t st;
    sfr_pkg::sfr_width_t in_w;
    sfr_pkg::sfr_width_t out_w;
    logic [7:0] op;
    logic [5:0] cnt;
    logic [23:0] addr;
    logic [7:0] mode;
    logic [7:0] shreg;
    logic [3:0] bitp;
    logic cont_dio;
    logic cont_qio;
    logic [3:0] dout;
    logic [3:0] doe;
    logic ld;
  } sfr_reg_t;

  sfr_reg_t r_ff, nxt_r;
  logic [7:0] mem_rd;

  // The array is addressed with the next address, so its registered data is ready at the load.
  sfr_mem #(.AW(`SFR_ADDR_W), .DEPTH_W(MEM_DEPTH_W)) u_mem (
    .clk(CORE_CLK),
    .addr(nxt_r.addr),
    .rdata(mem_rd)
  );

  function automatic logic [2:0] bits_per(input sfr_width_t w);
    case (w)
      SFR_W2: bits_per = 3'h2;
      SFR_W4: bits_per = 3'h4;
      default: bits_per = 3'h1;
    endcase
  endfunction

  logic cs_n_s, rise, fall;
  logic [3:0] io_s;
  logic [2:0] nb;
  logic [7:0] shin;
  logic [5:0] cnt1;

  always_comb begin
    nxt_r = r_ff;
    nxt_r.cs_s = {r_ff.cs_s[0], CS_N};
    nxt_r.ck_s = {r_ff.ck_s[0], SCLK};
    nxt_r.io0_s = {r_ff.io0_s[3:0], IO_IN};
    nxt_r.ck_d = r_ff.ck_s[1];
    nxt_r.ld = 1'b0;
    cs_n_s = r_ff.cs_s[1];
    io_s = r_ff.io0_s[7:4];
    rise = r_ff.ck_s[1] & ~r_ff.ck_d;
    fall = ~r_ff.ck_s[1] & r_ff.ck_d;
    nb = bits_per(r_ff.in_w);
    cnt1 = r_ff.cnt + 6'h01;
    // Top line carries the most significant bit of each group.
    case (r_ff.in_w)
      SFR_W2: shin = {r_ff.shreg[5:0], io_s[1:0]};
      SFR_W4: shin = {r_ff.shreg[3:0], io_s};
      default: shin = {r_ff.shreg[6:0], io_s[0]};
    endcase
    if (cs_n_s) begin
      nxt_r.doe = 4'h0;
      nxt_r.cnt = 6'h00;
      nxt_r.in_w = SFR_W1;
      nxt_r.st = SFR_CMD;
      // Opcode-free mode starts straight with the address phase.
      if (r_ff.cont_qio) begin
        nxt_r.st = SFR_ADDR;
        nxt_r.op = `SFR_OP_QIO;
        nxt_r.in_w = SFR_W4;
      end else if (r_ff.cont_dio) begin
        nxt_r.st = SFR_ADDR;
        nxt_r.op = `SFR_OP_DIO;
        nxt_r.in_w = SFR_W2;
      end
    end else if (rise) begin
      case (r_ff.st)
        SFR_CMD: begin
          nxt_r.shreg = shin;
          nxt_r.cnt = cnt1;
          if (cnt1 == 6'h08) begin
            nxt_r.op = shin;
            nxt_r.cnt = 6'h00;
            nxt_r.st = SFR_ADDR;
            case (shin)
              `SFR_OP_READ: nxt_r.in_w = SFR_W1;
              `SFR_OP_FAST, `SFR_OP_DOUT: nxt_r.st = BUSY_FLAG ? SFR_SKIP : SFR_ADDR;
              `SFR_OP_DIO: begin
                nxt_r.st = BUSY_FLAG ? SFR_SKIP : SFR_ADDR;
                nxt_r.in_w = SFR_W2;
              end
              `SFR_OP_QOUT: nxt_r.st = (BUSY_FLAG | ~QUAD_LINES_ENABLE) ? SFR_SKIP : SFR_ADDR;
              `SFR_OP_QIO: begin
                nxt_r.st = (BUSY_FLAG | ~QUAD_LINES_ENABLE) ? SFR_SKIP : SFR_ADDR;
                nxt_r.in_w = SFR_W4;
              end
              `SFR_OP_CRST: begin
                nxt_r.cont_dio = 1'b0;
                nxt_r.cont_qio = 1'b0;
                nxt_r.st = SFR_SKIP;
              end
              default: nxt_r.st = SFR_SKIP;
            endcase
          end
        end
        SFR_ADDR: begin
          nxt_r.addr = (r_ff.addr << nb) | {20'h0, (r_ff.in_w == SFR_W4) ? io_s
                       : (r_ff.in_w == SFR_W2) ? {2'h0, io_s[1:0]} : {3'h0, io_s[0]}};
          nxt_r.cnt = cnt1;
          if (cnt1 == 6'(`SFR_ADDR_W / nb)) begin
            nxt_r.cnt = 6'h00;
            nxt_r.st = SFR_DUMMY;
            if (r_ff.op == `SFR_OP_READ) begin
              nxt_r.st = SFR_DATA;
              nxt_r.ld = 1'b1;
              nxt_r.bitp = 4'h0;
            end
          end
        end
        SFR_DUMMY: begin
          nxt_r.cnt = cnt1;
          // The mode byte fills the first eight dummy bits, whatever the line width.
          if (r_ff.cnt < 6'(8 / nb)) begin
            nxt_r.mode = shin;
            nxt_r.shreg = shin;
          end
          if ((r_ff.op == `SFR_OP_FAST && cnt1 == 6'(`SFR_DUMMY_X1)) ||
              (r_ff.op == `SFR_OP_DOUT && cnt1 == 6'(`SFR_DUMMY_DOUT)) ||
              (r_ff.op == `SFR_OP_QOUT && cnt1 == 6'(`SFR_DUMMY_QOUT)) ||
              (r_ff.op == `SFR_OP_DIO && cnt1 == 6'(`SFR_DUMMY_DIO)) ||
              (r_ff.op == `SFR_OP_QIO && cnt1 == 6'(`SFR_DUMMY_QIO))) begin
            nxt_r.st = SFR_DATA;
            nxt_r.ld = 1'b1;
            nxt_r.bitp = 4'h0;
            // On dual lines the last mode bits land on this edge, so the fresh value decides.
            if (r_ff.op == `SFR_OP_DIO) begin
              nxt_r.cont_dio = (nxt_r.mode[5:4] == `SFR_CONT_KEEP);
            end
            if (r_ff.op == `SFR_OP_QIO) begin
              nxt_r.cont_qio = (nxt_r.mode[5:4] == `SFR_CONT_KEEP);
            end
          end
        end
        default: nxt_r.st = r_ff.st;
      endcase
    end else if (fall && r_ff.st == SFR_DATA) begin
      nxt_r.out_w = (r_ff.op == `SFR_OP_DIO || r_ff.op == `SFR_OP_DOUT) ? SFR_W2 :
                    (r_ff.op == `SFR_OP_QIO || r_ff.op == `SFR_OP_QOUT) ? SFR_W4 : SFR_W1;
      case (nxt_r.out_w)
        SFR_W2: begin
          nxt_r.dout = {2'h0, r_ff.shreg[7:6]};
          nxt_r.doe = 4'h3;
        end
        SFR_W4: begin
          nxt_r.dout = r_ff.shreg[7:4];
          nxt_r.doe = 4'hF;
        end
        default: begin
          nxt_r.dout = {2'h0, r_ff.shreg[7], 1'b0};
          nxt_r.doe = 4'h2;
        end
      endcase
      nxt_r.shreg = r_ff.shreg << bits_per(nxt_r.out_w);
      nxt_r.bitp = r_ff.bitp + 4'(bits_per(nxt_r.out_w));
      if (nxt_r.bitp == 4'h8) begin
        nxt_r.bitp = 4'h0;
        nxt_r.ld = 1'b1;
      end
    end
    // The load lands one cycle after the request; the edge sampler is far slower.
    if (r_ff.ld) begin
      nxt_r.shreg = mem_rd;
      nxt_r.addr = r_ff.addr + 24'h1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      r_ff <= '0;
      r_ff.cs_s <= 2'h3;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign IO_OUT = r_ff.dout;
  assign IO_OE = r_ff.doe;
  assign CONT_MODE = r_ff.cont_dio | r_ff.cont_qio;
endmodule

// ---- bench/sfr_read_front_assertions.sv ----
`timescale 1ns/1ps
module sfr_read_front_assertions (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic CS_N,
  input wire logic SCLK,
  input wire logic BUSY_FLAG,
  input wire logic QUAD_LINES_ENABLE,
  input wire logic [3:0] IO_OUT,
  input wire logic [3:0] IO_OE,
  input wire logic CONT_MODE
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);
  a_quiet_start: assert property ($fell(CS_N) |-> (IO_OE == 4'h0) [*8])
    else $error("early enable");
  a_out_settled: assert property ($rose(SCLK) |-> ##3 $stable(IO_OUT) [*3])
    else $error("output moved in high phase");
  a_data_ones: assert property ((IO_OE != 4'h0) && ($past(IO_OE) != 4'h0)
    |-> (IO_OUT & IO_OE) == IO_OE) else $error("erased data not ones");
  a_oe_release: assert property ($rose(CS_N) |-> ##5 IO_OE == 4'h0)
    else $error("driving after deselect");
  a_busy_quiet: assert property (BUSY_FLAG [*8] |-> !IO_OE[0])
    else $error("wide read served while busy");
  a_cont_hold: assert property (CS_N [*6] |=> $stable(CONT_MODE))
    else $error("continuation moved while idle");
  a_quad_gate: assert property (!QUAD_LINES_ENABLE [*8] |-> IO_OE[3:2] == 2'h0)
    else $error("quad lines without enable");
  a_oe_legal: assert property (IO_OE inside {4'h0, 4'h2, 4'h3, 4'hF})
    else $error("bad enable pattern");
endmodule

// ---- bench/sfr_host_model.sv ----
`timescale 1ns/1ps
module sfr_host_model (
  input wire logic clk,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe,
  output logic cs_n = 1'b1,
  output logic sclk = 1'b0,
  output logic [3:0] io_in
);
  logic [3:0] hv = 4'h0;
  logic [3:0] hoe = 4'h0;
  // A released line shows the inverse of its last value, so a stale level never passes.
  assign io_in = (io_oe & io_out) | (~io_oe & ~(hoe ^ hv));
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic sel(input logic v);
    cs_n = v;
    hoe = 4'h0;
    wait_n(6);
  endtask
  // Clock moves only inside a frame; lines change while it is low.
  task automatic tick(input logic [3:0] v, input logic [3:0] en, output logic [3:0] g);
    hv = v;
    hoe = en;
    wait_n(4);
    sclk = 1'b1;
    wait_n(2);
    g = io_out;
    wait_n(2);
    sclk = 1'b0;
  endtask
  task automatic send(input logic [31:0] v, input int nb, input int w);
    logic [3:0] g;
    for (int i = nb - w; i >= 0; i -= w) begin
      tick(4'((v >> i) & ((1 << w) - 1)), 4'((1 << w) - 1), g);
    end
  endtask
endmodule

// ---- bench/sfr_read_front_bench.sv ----
`timescale 1ns/1ps
module sfr_read_front_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic busy = 1'b0;
  logic qen = 1'b0;
  logic cs_n;
  logic sclk;
  logic cont;
  logic [3:0] io_in;
  logic [3:0] io_out;
  logic [3:0] io_oe;
  logic [7:0] bops [5] = '{8'h0B, 8'h3B, 8'hBB, 8'h6B, 8'hEB};
  int err_count = 0;
  int samples_checked = 0;
  always #50 clk = ~clk;
  sfr_host_model host (.clk(clk), .io_out(io_out), .io_oe(io_oe), .cs_n(cs_n), .sclk(sclk),
    .io_in(io_in));
  sfr_read_front DUT (.CORE_CLK(clk), .RST_N(rst_n), .CS_N(cs_n), .SCLK(sclk), .IO_IN(io_in),
    .IO_OUT(io_out), .IO_OE(io_oe), .BUSY_FLAG(busy), .QUAD_LINES_ENABLE(qen), .CONT_MODE(cont));
  task automatic end_sim;
    if (err_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] s);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, e, s);
    end
  endtask
  // Opcode 00 stands for a continuation frame; the address sits just below the wrap point.
  task automatic rd(input logic [7:0] op, input int aw, input logic [7:0] md, input int dc,
      input logic [3:0] eoe, input int n);
    logic [3:0] g;
    host.sel(1'b0);
    if (op != 8'h00) begin
      host.send({24'h0, op}, 8, 1);
    end
    host.send(32'hFFFFFE, 24, aw);
    if (aw > 1) begin
      host.send({24'h0, md}, 8, aw);
    end
    host.send(32'h0, (aw > 1) ? dc - 8 / aw : dc, 1);
    repeat (n) begin
      host.tick(4'h0, 4'h0, g);
      chk("enable", {4'h0, eoe}, {4'h0, io_oe});
      chk("data", {4'h0, eoe}, {4'h0, g & io_oe});
    end
    host.sel(1'b1);
    chk("release", 8'h00, {4'h0, io_oe});
  endtask
  task automatic t_single;
    rd(8'h03, 1, 8'h00, 0, 4'h2, 19);
    rd(8'h0B, 1, 8'h00, 8, 4'h2, 8);
  endtask
  task automatic t_dual;
    rd(8'h3B, 1, 8'h00, 8, 4'h3, 8);
    rd(8'hBB, 2, 8'h20, 4, 4'h3, 8);
    chk("cont", 8'h01, {7'h0, cont});
    rd(8'h00, 2, 8'h00, 4, 4'h3, 4);
    chk("cont", 8'h00, {7'h0, cont});
    rd(8'hFF, 1, 8'h00, 0, 4'h0, 2);
    chk("cont", 8'h00, {7'h0, cont});
  endtask
  task automatic t_quad;
    rd(8'h6B, 1, 8'h00, 8, 4'h0, 4);
    qen = 1'b1;
    rd(8'h6B, 1, 8'h00, 8, 4'hF, 4);
    rd(8'hEB, 4, 8'h20, 6, 4'hF, 4);
    chk("cont", 8'h01, {7'h0, cont});
    rd(8'h00, 4, 8'h00, 6, 4'hF, 4);
    chk("cont", 8'h00, {7'h0, cont});
  endtask
  task automatic t_busy;
    busy = 1'b1;
    foreach (bops[i]) begin
      rd(bops[i], 1, 8'h00, 8, 4'h0, 4);
    end
    rd(8'h03, 1, 8'h00, 0, 4'h2, 8);
    busy = 1'b0;
  endtask
  initial begin
    host.wait_n(10);
    rst_n = 1'b1;
    host.wait_n(3);
    t_single;
    t_dual;
    t_quad;
    t_busy;
    end_sim;
  end
endmodule
bind sfr_read_front sfr_read_front_assertions u_chk (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
  .CS_N(CS_N), .SCLK(SCLK), .BUSY_FLAG(BUSY_FLAG), .QUAD_LINES_ENABLE(QUAD_LINES_ENABLE),
  .IO_OUT(IO_OUT), .IO_OE(IO_OE), .CONT_MODE(CONT_MODE));
